// *** pkg/srg_defs.vh ***
`ifndef SRG_DEFS_VH
`define SRG_DEFS_VH

// Register byte offsets
`define SRG_CFG_ONE_ADDR 8'h00
`define SRG_CFG_TWO_ADDR 8'h04
`define SRG_PIN_CTRL_ADDR 8'h08
`define SRG_PORT_CTRL_ADDR 8'h0C
`define SRG_STATUS_ADDR 8'h10

// rate_gen_config_one fields
`define SRG_DIV_LSB 0
`define SRG_DIV_MSB 7
`define SRG_FRAME_WIDTH_FIELD_LSB 8
`define SRG_FRAME_WIDTH_FIELD_MSB 15

// rate_gen_config_two fields
`define SRG_FRAME_PERIOD_FIELD_LSB 0
`define SRG_FRAME_PERIOD_FIELD_MSB 11
`define SRG_TX_FROM_GEN_BIT 12
`define SRG_SRC_MODE_BIT 13
`define SRG_RESYNC_BIT 15

// pin_control_reg fields
`define SRG_RX_CLK_POL_BIT 0
`define SRG_TX_CLK_POL_BIT 1
`define SRG_SRC_PIN_SEL_BIT 2
`define SRG_RX_CLK_INT_BIT 8
`define SRG_TX_CLK_INT_BIT 9
`define SRG_RX_FRM_INT_BIT 10
`define SRG_TX_FRM_INT_BIT 11

// port control fields (active-low resets)
`define SRG_RX_RST_N_BIT 0
`define SRG_TX_RST_N_BIT 1
`define SRG_GEN_RST_N_BIT 2
`define SRG_FRM_RST_N_BIT 3

// Status fields
`define SRG_ST_CLK_BIT 0
`define SRG_ST_FRM_BIT 1
`define SRG_ST_SYNCED_BIT 2

// Reset values
`define SRG_CFG_ONE_RST 16'h0001
`define SRG_CFG_TWO_RST 16'h2000
`define SRG_PIN_CTRL_RST 12'h000
`define SRG_PORT_CTRL_RST 4'h0

// Divider input selection codes {pin select, mode}
`define SRG_SEL_RESERVED 2'b00
`define SRG_SEL_PERIPH 2'b01
`define SRG_SEL_RX_PIN 2'b10
`define SRG_SEL_TX_PIN 2'b11

// AHB transfer type
`define SRG_HTRANS_NONSEQ 2'b10

`endif

// *** design/srg_rate_gen.v ***
// Notes on behaviour
// - With resync on, each rising receive frame-sync restarts divider and emits one frame pulse.
// - Sample clock starts high after every resynchronisation.
// - Frame-sync is sampled on the same input-clock tick that advances the divider.
// - In resync mode the frame period field is ignored; external pulses set the period.
// - Resync off: clock runs free, frame period comes from the frame period field.
// - Resynchronisation applies only when an external clock pin feeds the divider.
// - Divider input select: 00 reserved, 01 peripheral clock, 10 rx pin, 11 tx pin.
// - Lockstep transmit needs generator frame pulse and sample clock on both port clocks.
// - Device reset clears generator, frame, receiver and transmitter reset bits.
// - During device reset sample clock toggles at clock/2, frame pulse stays low.
// - Software generator reset holds sample clock and frame pulse low.
// - After release the sample clock goes high on next tick, divides by field plus one.
// - First frame pulse rises after frame period field plus one sample clocks.
// - Frame width field 0 gives a pulse one sample clock wide.
// - Resynced frame pulse is regenerated with a minimum width of whole sample clocks.
// - In resync mode the clock free-runs until the first external frame-sync.
// - Each frame pulse lasts frame width field plus one sample clocks.
// - Duty 50% for even divide; odd 2p+1 gives p+1 high, p low.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "srg_defs.vh"

module srg_rate_gen #(
  parameter DIV_W = 8,
  parameter FRAME_WIDTH_FIELD_W = 8,
  parameter FRAME_PERIOD_FIELD_W = 12
) (
  input wire clk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rxClockPinIn,
  output reg rxClockPinOut,
  output reg rxClockPinOe,
  input wire txClockPinIn,
  output reg txClockPinOut,
  output reg txClockPinOe,
  input wire rxFrameSyncPin,
  output reg txFrameSyncPinOut,
  output reg txFrameSyncPinOe,
  output reg sampleClockOut,
  output reg generatedFramePulse,
  output reg receiverResetN,
  output reg transmitterResetN
);

////////////////////////////////////////////////////////////////////////////////
// Register file and AHB-Lite slave

reg [15:0] cfgOne;
reg [15:0] cfgTwo;
reg [11:0] pinCtrl;
reg [3:0] portCtrl;
reg wrPending;
reg [7:0] wrAddr;
reg synced;

wire addrValid = hsel && hready && (htrans == `SRG_HTRANS_NONSEQ);
wire [7:0] addrLow = haddr[7:0];
wire [31:0] statusWord = {29'h0, synced, generatedFramePulse, sampleClockOut};
wire inRange = (haddr[31:8] == 24'h000000);
reg [31:0] next_hrdata;

always @* begin
  next_hrdata = 32'h00000000;
  if (addrValid && !hwrite && inRange) begin
    case (addrLow)
      `SRG_CFG_ONE_ADDR: next_hrdata = {16'h0000, cfgOne};
      `SRG_CFG_TWO_ADDR: next_hrdata = {16'h0000, cfgTwo};
      `SRG_PIN_CTRL_ADDR: next_hrdata = {20'h00000, pinCtrl};
      `SRG_PORT_CTRL_ADDR: next_hrdata = {28'h0000000, portCtrl};
      `SRG_STATUS_ADDR: next_hrdata = statusWord;
      default: next_hrdata = 32'h00000000;
    endcase
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    hrdata <= 32'h00000000;
    hreadyout <= 1'b0;
    hresp <= 1'b0;
    wrPending <= 1'b0;
    wrAddr <= 8'h00;
    cfgOne <= `SRG_CFG_ONE_RST;
    cfgTwo <= `SRG_CFG_TWO_RST;
    pinCtrl <= `SRG_PIN_CTRL_RST;
    portCtrl <= `SRG_PORT_CTRL_RST;
  end else begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    hrdata <= next_hrdata;
    wrPending <= addrValid && hwrite && inRange;
    wrAddr <= addrLow;
    if (wrPending) begin
      case (wrAddr)
        `SRG_CFG_ONE_ADDR: cfgOne <= hwdata[15:0];
        `SRG_CFG_TWO_ADDR: cfgTwo <= hwdata[15:0];
        `SRG_PIN_CTRL_ADDR: pinCtrl <= hwdata[11:0];
        `SRG_PORT_CTRL_ADDR: portCtrl <= hwdata[3:0];
        default: portCtrl <= portCtrl;
      endcase
    end
  end
end

wire [DIV_W-1:0] divField = cfgOne[`SRG_DIV_MSB:`SRG_DIV_LSB];
wire [FRAME_WIDTH_FIELD_W-1:0] widthField = cfgOne[`SRG_FRAME_WIDTH_FIELD_MSB:`SRG_FRAME_WIDTH_FIELD_LSB];
wire [FRAME_PERIOD_FIELD_W-1:0] periodField = cfgTwo[`SRG_FRAME_PERIOD_FIELD_MSB:`SRG_FRAME_PERIOD_FIELD_LSB];
wire resyncEnable = cfgTwo[`SRG_RESYNC_BIT];
wire genRunN = portCtrl[`SRG_GEN_RST_N_BIT];
wire frameRunN = portCtrl[`SRG_FRM_RST_N_BIT];
wire [1:0] srcSel = {pinCtrl[`SRG_SRC_PIN_SEL_BIT], cfgTwo[`SRG_SRC_MODE_BIT]};

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and divider input tick

reg [1:0] rxClkSync;
reg [1:0] txClkSync;
reg [1:0] fsSync;
reg rxClkLast;
reg txClkLast;

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    rxClkSync <= 2'b00;
    txClkSync <= 2'b00;
    fsSync <= 2'b00;
    rxClkLast <= 1'b0;
    txClkLast <= 1'b0;
  end else begin
    rxClkSync <= {rxClkSync[0], rxClockPinIn};
    txClkSync <= {txClkSync[0], txClockPinIn};
    fsSync <= {fsSync[0], rxFrameSyncPin};
    rxClkLast <= rxClkSync[1];
    txClkLast <= txClkSync[1];
  end
end

wire rxRise = rxClkSync[1] && !rxClkLast;
wire rxFall = !rxClkSync[1] && rxClkLast;
wire txRise = txClkSync[1] && !txClkLast;
wire txFall = !txClkSync[1] && txClkLast;
reg tick;

// divider input selection, with pin polarity applied
always @* begin
  case (srcSel)
    `SRG_SEL_PERIPH: tick = 1'b1;
    `SRG_SEL_RX_PIN: tick = pinCtrl[`SRG_RX_CLK_POL_BIT] ? rxRise : rxFall;
    `SRG_SEL_TX_PIN: tick = pinCtrl[`SRG_TX_CLK_POL_BIT] ? txFall : txRise;
    default: tick = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Clock divider with resynchronisation

// resync only with an external pin as divider input
wire resyncMode = resyncEnable && srcSel[1];
reg fsAtTick;
reg [DIV_W-1:0] divCnt;
reg clkLevel;

// frame-sync edge taken on the divider tick
wire resyncEvent = resyncMode && tick && fsSync[1] && !fsAtTick;
// reload on zero or on resync
wire reload = tick && ((divCnt == {DIV_W{1'b0}}) || resyncEvent);
wire [DIV_W-1:0] next_divCnt = reload ? divField : divCnt - {{(DIV_W-1){1'b0}}, 1'b1};
// high while count is in the upper part of the period
wire [DIV_W-1:0] highThresh = divField - (divField >> 1);
wire next_clkLevel = (next_divCnt >= highThresh);

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    fsAtTick <= 1'b0;
    divCnt <= {DIV_W{1'b0}};
    clkLevel <= 1'b0;
    synced <= 1'b0;
  end else if (!genRunN) begin
    // Count parked at zero so the first tick after release reloads
    fsAtTick <= fsSync[1];
    divCnt <= {DIV_W{1'b0}};
    clkLevel <= 1'b0;
    synced <= 1'b0;
  end else begin
    if (tick) begin
      fsAtTick <= fsSync[1];
    end
    // first tick after release reloads and drives high
    // free-running until the first resync event
    if (tick) begin
      divCnt <= next_divCnt;
      clkLevel <= next_clkLevel;
    end
    if (!resyncMode) begin
      synced <= 1'b0;
    end else if (resyncEvent) begin
      synced <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Frame pulse generator

reg [FRAME_PERIOD_FIELD_W-1:0] perCnt;
reg [FRAME_WIDTH_FIELD_W-1:0] widCnt;
reg frameLevel;
wire sampleRise = reload && genRunN;
// period field ignored in resync mode
wire frameStart = resyncMode ? resyncEvent : (sampleRise && perCnt == {FRAME_PERIOD_FIELD_W{1'b0}});

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    perCnt <= {FRAME_PERIOD_FIELD_W{1'b0}};
    widCnt <= {FRAME_WIDTH_FIELD_W{1'b0}};
    frameLevel <= 1'b0;
  end else if (!genRunN || !frameRunN) begin
    // first pulse after period field plus one sample clocks
    perCnt <= periodField;
    widCnt <= {FRAME_WIDTH_FIELD_W{1'b0}};
    frameLevel <= 1'b0;
  end else begin
    if (sampleRise) begin
      perCnt <= (perCnt == {FRAME_PERIOD_FIELD_W{1'b0}}) ? periodField : perCnt - {{(FRAME_PERIOD_FIELD_W-1){1'b0}}, 1'b1};
    end
    // width field plus one whole sample clocks
    if (frameStart) begin
      frameLevel <= 1'b1;
      widCnt <= widthField;
    end else if (sampleRise && frameLevel) begin
      if (widCnt == {FRAME_WIDTH_FIELD_W{1'b0}}) begin
        frameLevel <= 1'b0;
      end else begin
        widCnt <= widCnt - {{(FRAME_WIDTH_FIELD_W-1){1'b0}}, 1'b1};
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output flops

// No async reset: this flop must keep toggling while the device reset is held
always @(posedge clk) begin
  if (!reset_n) begin
    // sample clock at clock/2 under device reset
    case (sampleClockOut)
      1'b1: sampleClockOut <= 1'b0;
      default: sampleClockOut <= 1'b1;
    endcase
  end else begin
    // held low under software generator reset
    sampleClockOut <= genRunN && clkLevel;
  end
end

wire rxClkInt = pinCtrl[`SRG_RX_CLK_INT_BIT];
wire txClkInt = pinCtrl[`SRG_TX_CLK_INT_BIT];
wire txFrmInt = pinCtrl[`SRG_TX_FRM_INT_BIT];
wire txFromGen = cfgTwo[`SRG_TX_FROM_GEN_BIT];

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    // frame pulse low under device reset
    generatedFramePulse <= 1'b0;
    rxClockPinOut <= 1'b0;
    rxClockPinOe <= 1'b0;
    txClockPinOut <= 1'b0;
    txClockPinOe <= 1'b0;
    txFrameSyncPinOut <= 1'b0;
    txFrameSyncPinOe <= 1'b0;
    receiverResetN <= 1'b0;
    transmitterResetN <= 1'b0;
  end else begin
    // frame pulse low under software reset
    generatedFramePulse <= genRunN && frameRunN && frameLevel;
    // port clocks and tx frame taken from the generator
    rxClockPinOut <= rxClkInt && genRunN && clkLevel;
    rxClockPinOe <= rxClkInt;
    txClockPinOut <= txClkInt && genRunN && clkLevel;
    txClockPinOe <= txClkInt;
    txFrameSyncPinOut <= txFrmInt && txFromGen && genRunN && frameRunN && frameLevel;
    txFrameSyncPinOe <= txFrmInt;
    receiverResetN <= portCtrl[`SRG_RX_RST_N_BIT];
    transmitterResetN <= portCtrl[`SRG_TX_RST_N_BIT];
  end
end

endmodule // srg_rate_gen

// *** tb/srg_partner.sv ***
`timescale 1ns/10ps
module srg_partner #(
  parameter int HALF = 300,
  parameter int GAP = 8
) (
  output logic pinClk,
  output logic frameSync
);
  int k = 0;
  // Offset keeps pin edges clear of the system clock edges
  initial begin
    pinClk = 1'b0;
    frameSync = 1'b0;
    #37;
    forever begin
      #HALF pinClk = 1'b1;
      #HALF pinClk = 1'b0;
      frameSync = k % GAP == 0;
      k++;
    end
  end
endmodule // srg_partner

// *** tb/srg_rate_gen_chk.sv ***
`timescale 1ns/10ps
`include "srg_defs.vh"
module srg_chk (
  input wire clk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire txFrameSyncPinOut,
  input wire txFrameSyncPinOe,
  input wire sampleClockOut,
  input wire generatedFramePulse,
  input wire receiverResetN,
  input wire transmitterResetN
);
  reg [15:0] r [0:3];
  reg wp;
  reg [1:0] wa;
  wire [3:0] pc = r[3][3:0];
  wire per = !r[2][2] && r[1][13];
  // Shadow of written registers, so the checks know the programmed mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp <= 1'b0;
      wa <= 2'h0;
      r[1] <= 16'h2000;
      r[2] <= 16'h0000;
      r[3] <= 16'h0000;
    end else begin
      wp <= hsel && hready && htrans == `SRG_HTRANS_NONSEQ && hwrite && haddr[31:4] == 28'h0;
      wa <= haddr[3:2];
      if (wp) r[wa] <= hwdata[15:0];
    end
  end
  ////////////////////////////////////////
  property p_rstBits; @(posedge clk) !reset_n |-> !receiverResetN && !transmitterResetN && !generatedFramePulse; endproperty
  a_rstBits: assert property (p_rstBits) else $error("reset bits not low");
  property p_rstClk; @(posedge clk) (!reset_n) [*3] |-> sampleClockOut != $past(sampleClockOut); endproperty
  a_rstClk: assert property (p_rstClk) else $error("clock not toggling in reset");
  property p_bitCopy; @(posedge clk) disable iff (!reset_n) $stable(pc) |-> receiverResetN == pc[0] && transmitterResetN == pc[1]; endproperty
  a_bitCopy: assert property (p_bitCopy) else $error("section reset outputs wrong");
  property p_genOff; @(posedge clk) disable iff (!reset_n) !pc[2] [*3] |-> !sampleClockOut && !generatedFramePulse; endproperty
  a_genOff: assert property (p_genOff) else $error("outputs active in generator reset");
  property p_frmOff; @(posedge clk) disable iff (!reset_n) !pc[3] [*3] |-> !generatedFramePulse; endproperty
  a_frmOff: assert property (p_frmOff) else $error("pulse in frame reset");
  property p_clkRise; @(posedge clk) disable iff (!reset_n) $rose(pc[2]) && per |-> ##2 sampleClockOut; endproperty
  a_clkRise: assert property (p_clkRise) else $error("clock not high after release");
  property p_txFrm; @(posedge clk) disable iff (!reset_n) txFrameSyncPinOut |-> txFrameSyncPinOe; endproperty
  a_txFrm: assert property (p_txFrm) else $error("frame pin driven while off");
  property p_ready; @(posedge clk) disable iff (!reset_n) $past(reset_n) |-> hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");
endmodule // srg_chk
bind srg_rate_gen srg_chk srg_chk_inst (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .txFrameSyncPinOut, .txFrameSyncPinOe, .sampleClockOut, .generatedFramePulse,
  .receiverResetN, .transmitterResetN);

// *** tb/srg_rate_gen_tb_top.sv ***
`timescale 1ns/10ps
`include "srg_defs.vh"
`define CHK(a, e) begin cA = (a); cE = (e); check_count++; if (cA !== cE) begin n_fail++; $display("ERROR t=%0t %h %h", $time, cA, cE); end end
module srg_rate_gen_tb_top;
  logic clk = 1'b0, reset_n = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdPh = 1'b0, scD = 1'b0, fpD = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h3E;
  logic [1:0] htrans = 2'h0;
  // Operands are latched once so a queue pop is never repeated by the report
  logic [63:0] cA, cE;
  logic [31:0] qRd[$];
  int qHi[$], qFw[$], qPer[$];
  int n_fail = 0, check_count = 0, hiC = 0, fwC = 0, prC = 0;
  wire [31:0] hrdata;
  wire hreadyout, pinClk, frameSync, sampleClockOut, generatedFramePulse;
  initial forever #50 clk = ~clk;
  srg_partner srg_partner_inst (.pinClk, .frameSync);
  srg_rate_gen srg_rate_gen_inst (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .rxClockPinIn(pinClk), .rxClockPinOut(), .rxClockPinOe(),
    .txClockPinIn(pinClk), .txClockPinOut(), .txClockPinOe(), .rxFrameSyncPin(frameSync), .txFrameSyncPinOut(),
    .txFrameSyncPinOe(), .sampleClockOut, .generatedFramePulse, .receiverResetN(), .transmitterResetN());
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= `SRG_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (!hreadyout && n++ < 99) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !w;
    @(posedge clk);
    while (!hreadyout && n++ < 99) @(posedge clk);
    rdPh <= 1'b0;
    if (n >= 99) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    qRd.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  ////////////////////////////////////////
  // Counts are in clk cycles; a queue entry of -1 skips one partial period
  always @(posedge clk) begin
    hiC <= sampleClockOut ? hiC + 1 : 0;
    fwC <= generatedFramePulse ? fwC + 1 : 0;
    prC <= (generatedFramePulse && !fpD) ? 1 : prC + 1;
    scD <= sampleClockOut;
    fpD <= generatedFramePulse;
    if (rdPh && hreadyout) `CHK(hrdata, qRd.pop_front())
    if (!sampleClockOut && scD && qHi.size() > 0) `CHK(hiC, qHi.pop_front())
    if (!generatedFramePulse && fpD && qFw.size() > 0) `CHK(fwC, qFw.pop_front())
    if (generatedFramePulse && !fpD && qPer.size() > 0) begin
      if (qPer[0] < 0) void'(qPer.pop_front());
      else `CHK(prC, qPer.pop_front())
    end
  end
  initial begin
    logic [31:0] v;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`SRG_CFG_ONE_ADDR, 32'h1);
    rd(`SRG_CFG_TWO_ADDR, 32'h2000);
    rd(`SRG_PIN_CTRL_ADDR, 32'h0);
    rd(`SRG_PORT_CTRL_ADDR, 32'h0);
    v = rnd();
    wr(8'h40, v);
    rd(8'h40, 32'h0);
    wr(`SRG_CFG_ONE_ADDR, v);
    rd(`SRG_CFG_ONE_ADDR, v & 32'hFFFF);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(`SRG_PORT_CTRL_ADDR, 32'h0);
      wr(`SRG_CFG_ONE_ADDR, i * 256 + i + 1);
      wr(`SRG_CFG_TWO_ADDR, 32'h3000 + 2 * i + 3);
      wr(`SRG_PIN_CTRL_ADDR, 32'h0B00);
      repeat (2) @(posedge clk);
      qHi.push_back((i + 1) / 2 + 1);
      qFw.push_back((i + 1) * (i + 2));
      qPer.push_back(-1);
      qPer.push_back((2 * i + 4) * (i + 2));
      wr(`SRG_PORT_CTRL_ADDR, 32'hF);
      repeat (100) @(posedge clk);
    end
    $display("test free run done");
    wr(`SRG_PORT_CTRL_ADDR, 32'h0);
    wr(`SRG_CFG_TWO_ADDR, 32'h1001);
    repeat (2) @(posedge clk);
    wr(`SRG_PORT_CTRL_ADDR, 32'hF);
    repeat (50) @(posedge clk);
    `CHK(generatedFramePulse, 1'b0)
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`SRG_PORT_CTRL_ADDR, 32'h0);
    $display("test reserved source and reset done");
    for (int m = 0; m < 3; m++) begin
      wr(`SRG_PORT_CTRL_ADDR, 32'h0);
      wr(`SRG_CFG_ONE_ADDR, 32'h1);
      wr(`SRG_CFG_TWO_ADDR, m ? 32'hB002 : 32'h9002);
      wr(`SRG_PIN_CTRL_ADDR, m == 2 ? 32'h0B01 : 32'h0B05);
      repeat (12) @(posedge clk);
      qFw.push_back(m == 2 ? 2 : 12);
      qPer.push_back(-1);
      qPer.push_back(m == 2 ? 6 : 48);
      wr(`SRG_PORT_CTRL_ADDR, 32'hF);
      repeat (150) @(posedge clk);
    end
    $display("test resync done");
    `CHK(qHi.size() + qFw.size() + qPer.size(), 0)
    stop_test();
  end
endmodule // srg_rate_gen_tb_top
